// ### logic/observe_pin_signal_select.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module observe_pin_signal_select
  import observe_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire observe_sources_t sources,
  output logic                  observe_output_pin,
  output logic                  observe_output_pin_oe,
  output logic                  pad_fast_switching
);

  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = ({a[31:2], 2'b00} == OBS_CTRL_BYTE);
  endfunction

  logic [7:0]  ctrl_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [31:0] awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;

  wire       do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire       wr_hit    = addr_hit(awaddr_reg);
  wire       ctrl_wen  = do_write && wr_hit && wstrb0_reg;
  wire       aw_take   = s_axi_awvalid && s_axi_awready;
  wire       w_take    = s_axi_wvalid && s_axi_wready;
  wire       ar_take   = s_axi_arvalid && s_axi_arready;
  wire       ar_hit    = addr_hit(s_axi_araddr);
  wire [7:0] ctrl_next = ctrl_wen ? (wdata_reg & OBS_CTRL_WMASK) : ctrl_reg; // R11
  wire [3:0] sel       = ctrl_reg[SEL_MSB:0];

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= OBS_CTRL_RESET;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 32'h0000_0000;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ar_hit ? {24'h000000, ctrl_reg} : 32'h0000_0000; // R11
      s_axi_rresp  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic pin_next;
  logic oe_next;
  always_comb begin
    pin_next = 1'b0;
    oe_next  = 1'b1;
    case (sel)
      SEL_HIZ0, SEL_HIZ1: oe_next = 1'b0;                          // R1
      SEL_LOW:    pin_next = 1'b0;                                  // R2
      SEL_HIGH:   pin_next = 1'b1;                                  // R3
      SEL_TX_ENV: pin_next = sources.tx_envelope;                   // R4
      SEL_TX_ACT: pin_next = sources.tx_active;                     // R5
      SEL_LINK:   pin_next = sources.generic_secure_link_signal;    // R6
      SEL_RX_ENV: pin_next = sources.rx_envelope;                   // R7
      SEL_RX_ACT: pin_next = sources.rx_active;                     // R8
      SEL_RX_BIT: pin_next = sources.rx_bit;                        // R9
      default:    oe_next  = 1'b0;                                  // R11
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      observe_output_pin    <= 1'b0;
      observe_output_pin_oe <= 1'b0;
      pad_fast_switching    <= 1'b0;
    end else begin
      observe_output_pin    <= pin_next;
      observe_output_pin_oe <= oe_next;
      pad_fast_switching    <= ctrl_reg[PAD_FAST_BIT];              // R10
    end
  end

  sequence sel_is(logic [3:0] c);
    sel == c;
  endsequence

  sequence reg_write;
    ctrl_wen;
  endsequence

  sequence write_held;
    do_write;
  endsequence

  sequence write_miss;
    do_write && !wr_hit;
  endsequence

  sequence write_nostrobe;
    do_write && wr_hit && !wstrb0_reg;
  endsequence

  sequence read_taken;
    ar_take;
  endsequence

  sequence read_hit;
    ar_take && ar_hit;
  endsequence

  sequence read_miss;
    ar_take && !ar_hit;
  endsequence

  sequence hiz_code_lands;
    ctrl_wen ##1 ((sel < 4'h2) || (sel > 4'h9));
  endsequence

  sequence driven_code_lands;
    ctrl_wen ##1 ((sel > 4'h1) && (sel < 4'hA));
  endsequence

  sequence pad_write_lands;
    ctrl_wen ##1 1'b1;
  endsequence

  hiz_low_codes_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (sel < 4'h2) |=> !observe_output_pin_oe)
    else $error("pin driven for hiz code");

  const_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    sel_is(4'h2) |=> observe_output_pin_oe && !observe_output_pin)
    else $error("pin not low");

  const_high_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    sel_is(4'h3) |=> observe_output_pin_oe && observe_output_pin)
    else $error("pin not high");

  tx_env_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    sel_is(4'h4) |=> observe_output_pin == $past(sources.tx_envelope))
    else $error("tx envelope not routed");

  tx_act_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    sel_is(4'h5) |=> observe_output_pin == $past(sources.tx_active))
    else $error("tx active not routed");

  link_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    sel_is(4'h6) |=> observe_output_pin == $past(sources.generic_secure_link_signal))
    else $error("link signal not routed");

  rx_env_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    sel_is(4'h7) |=> observe_output_pin == $past(sources.rx_envelope))
    else $error("rx envelope not routed");

  rx_act_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    sel_is(4'h8) |=> observe_output_pin == $past(sources.rx_active))
    else $error("rx active not routed");

  rx_bit_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    sel_is(4'h9) |=> observe_output_pin == $past(sources.rx_bit))
    else $error("rx bit not routed");

  pad_speed_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    pad_write_lands |=> pad_fast_switching == $past(wdata_reg[PAD_FAST_BIT], 2))
    else $error("pad speed not applied");

  unassigned_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (sel > 4'h9) |=> !observe_output_pin_oe)
    else $error("pin driven for unassigned code");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    s_axi_rvalid |-> s_axi_rdata[6:4] == 3'h0)
    else $error("reserved bits nonzero");

  reset_quiet_a: assert property (@(posedge aclk) // R1
    !aresetn |=> !observe_output_pin_oe && !pad_fast_switching && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");

  reset_ctrl_a: assert property (@(posedge aclk) // R11
    !aresetn |=> ctrl_reg == OBS_CTRL_RESET)
    else $error("control not at reset value");

  write_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    hiz_code_lands |=> !observe_output_pin_oe)
    else $error("pin driven after hiz code write");

  write_driven_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    driven_code_lands |=> observe_output_pin_oe)
    else $error("pin not driven after source code write");

  aw_refused_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    aw_held_reg |-> !s_axi_awready)
    else $error("second write address accepted");

  w_refused_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    w_held_reg |-> !s_axi_wready)
    else $error("second write data accepted");

  ar_refused_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answering");

  aw_capture_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    aw_take |=> aw_held_reg && (awaddr_reg == $past(s_axi_awaddr)))
    else $error("write address not captured");

  w_capture_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    w_take |=> w_held_reg && (wdata_reg == $past(s_axi_wdata[7:0])))
    else $error("write data not captured");

  held_release_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    write_held |=> !aw_held_reg && !w_held_reg)
    else $error("write halves not released");

  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    write_held |=> s_axi_bvalid)
    else $error("write response missing");

  hit_okay_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (do_write && wr_hit) |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write not okay");

  bvalid_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response not retired");

  ctrl_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    reg_write |=> ctrl_reg == $past(wdata_reg & OBS_CTRL_WMASK))
    else $error("control write not stored");

  ctrl_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    !ctrl_wen |=> $stable(ctrl_reg))
    else $error("control changed without write");

  nostrobe_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    write_nostrobe |=> $stable(ctrl_reg) && (s_axi_bresp == RESP_OKAY))
    else $error("strobeless write not ignored");

  miss_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    write_miss |=> $stable(ctrl_reg) && (s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");

  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    read_taken |=> s_axi_rvalid)
    else $error("read response missing");

  read_data_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    read_hit |=> (s_axi_rdata == {24'h000000, $past(ctrl_reg)}) && (s_axi_rresp == RESP_OKAY))
    else $error("mapped read data wrong");

  miss_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    read_miss |=> (s_axi_rdata == 32'h0000_0000) && (s_axi_rresp == RESP_SLVERR))
    else $error("unmapped read not refused");

  rvalid_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read response not retired");

  upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits nonzero");

  reserved_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    ctrl_reg[6:4] == 3'h0)
    else $error("reserved bits stored");

  pad_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    1'b1 |=> pad_fast_switching == $past(ctrl_reg[PAD_FAST_BIT]))
    else $error("pad speed not following control");

endmodule // observe_pin_signal_select

// ### logic/observe_pkg.sv
// Summary of operation
// R1: Select codes 0 and 1 leave the observation pin undriven.
// R2: Select code 2 drives the observation pin low.
// R3: Select code 3 drives the observation pin high.
// R4: Select code 4 routes the transmit envelope to the pin.
// R5: Select code 5 shows transmission in progress on the pin.
// R6: Select code 6 shows the generic secure link signal.
// R7: Select code 7 shows the receive envelope, valid for type A lowest rate.
// R8: Select code 8 shows reception in progress on the pin.
// R9: Select code 9 shows the decoded receive bit stream.
// R10: Bit 7 set puts the I/O pads in fast switching mode.
// R11: Codes 10 to 15 keep the pin undriven; bits 6 to 4 read zero.
package observe_pkg;
  localparam logic [31:0] OBS_CTRL_ADDR   = 32'h0000_0047;
  localparam logic [31:0] OBS_CTRL_BYTE   = 32'h0000_011C;
  localparam int          PAD_FAST_BIT    = 7;
  localparam int          SEL_MSB         = 3;
  localparam logic [7:0]  OBS_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  OBS_CTRL_WMASK  = 8'h8F;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [3:0] {
    SEL_HIZ0     = 4'h0,
    SEL_HIZ1     = 4'h1,
    SEL_LOW      = 4'h2,
    SEL_HIGH     = 4'h3,
    SEL_TX_ENV   = 4'h4,
    SEL_TX_ACT   = 4'h5,
    SEL_LINK     = 4'h6,
    SEL_RX_ENV   = 4'h7,
    SEL_RX_ACT   = 4'h8,
    SEL_RX_BIT   = 4'h9
  } observe_sel_t;

  typedef struct packed {
    logic tx_envelope;
    logic tx_active;
    logic generic_secure_link_signal;
    logic rx_envelope;
    logic rx_active;
    logic rx_bit;
  } observe_sources_t;
endpackage

// ### tb/observe_pin_signal_select_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module observe_pin_signal_select_bench;
  import observe_pkg::*;
  logic             aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [31:0]      awaddr = 0, wdata = 0, araddr = 0, rdata, rd, wd;
  logic [3:0]       wstrb = 0;
  logic             awr, wrd, bv, arr, rv, pin, oe, pad, lvl, ha, hw;
  logic [1:0]       br, rr, resp;
  observe_sources_t src = '0;
  int               err_count = 0, total_checks = 0, cyc = 0;
  observe_pin_signal_select uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .sources(src), .observe_output_pin(pin), .observe_output_pin_oe(oe), .pad_fast_switching(pad));
  observe_probe probe (.pin(pin), .oe(oe), .level(lvl));
  initial forever #25 aclk = ~aclk;
  function automatic logic exp_pin(logic [3:0] s, observe_sources_t v);
    if (s == 4'h2 || s == 4'h3) return s[0];
    if (s >= 4'h4 && s <= 4'h9) return v[4'h9 - s];
    return 1'bz;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Ready and response sampled at the falling edge, acted on at the rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= s; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(negedge aclk);
      ha = awr && awv; hw = wrd && wv; done = bv && bready; resp = br;
      @(posedge aclk);
      if (ha) awv <= 0;
      if (hw) wv <= 0;
      if (done) bready <= 0;
    end while (!done);
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [31:0] a);
    araddr <= a; arv <= 1; rready <= 1;
    do begin
      @(negedge aclk);
      ha = arr && arv; hw = rv && rready; rd = rdata; resp = rr;
      @(posedge aclk);
      if (ha) arv <= 0;
      if (hw) rready <= 0;
    end while (!hw);
    @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rd = $urandom(32'h9c7b);
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdr(OBS_CTRL_BYTE);
    `CHK("reset ctrl", 32'h0000_0000, rd)
    `CHK("reset pin", 1'bz, lvl)
    `CHK("reset pad", 1'b0, pad)
    // Every select code twice, reserved bits and pad bit random
    for (int i = 0; i < 32; i++) begin
      wd = {$urandom()} & 32'hFFFF_FFF0 | 32'(i % 16);
      wr(OBS_CTRL_BYTE, wd, 4'hF);
      `CHK("bresp", RESP_OKAY, resp)
      rdr(OBS_CTRL_BYTE);
      `CHK("ctrl", {24'h0, wd[7:0] & 8'h8F}, rd)
      `CHK("rresp", RESP_OKAY, resp)
      repeat (4) begin
        src <= observe_sources_t'($urandom());
        @(posedge aclk);
        @(negedge aclk);
        `CHK("pin", exp_pin(wd[3:0], src), lvl)
        `CHK("pad", wd[7], pad)
        @(posedge aclk);
      end
      $display("test code %0d done", i % 16);
    end
    // No byte strobe and unmapped place leave the register alone
    wr(OBS_CTRL_BYTE, 32'h0000_0083, 4'h0);
    `CHK("nostrb bresp", RESP_OKAY, resp)
    wr(32'h0000_0200, 32'h0000_0083, 4'hF);
    `CHK("unmapped bresp", RESP_SLVERR, resp)
    rdr(32'h0000_0200);
    `CHK("unmapped rresp", RESP_SLVERR, resp)
    `CHK("unmapped rdata", 32'h0000_0000, rd)
    rdr(OBS_CTRL_BYTE);
    `CHK("kept ctrl", {24'h0, wd[7:0] & 8'h8F}, rd)
    $display("test refusals done");
    // Reset in mid-run returns the register to its reset value
    wr(OBS_CTRL_BYTE, 32'h0000_0083, 4'hF);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdr(OBS_CTRL_BYTE);
    `CHK("rerun ctrl", {24'h0, OBS_CTRL_RESET}, rd)
    `CHK("rerun pin", 1'bz, lvl)
    `CHK("rerun pad", 1'b0, pad)
    $display("test mid reset done");
    test_done();
  end
endmodule // observe_pin_signal_select_bench

// ### tb/observe_probe.sv
`timescale 1ns/1ps
module observe_probe (
  input  wire logic pin,
  input  wire logic oe,
  output wire logic level
);
  // Undriven pin floats
  assign level = oe ? pin : 1'bz;
endmodule // observe_probe
